// file: gpio_bank.sv
// General-purpose I/O bank for ports 3-7, 12, 13 and 14 with its memory-mapped registers.
// Assumes a byte-wide register port synchronous to clock_in and pin levels already in sync.
//
// Operation
// - each mounted port 3 pin has its own direction bit
// - port 3 bits 0-2 get a per-pin pull-up when inputs
// - reset puts port 3 bits 0-2 in input mode
// - port 4 bits 0-3 have direction bits and input pull-ups
// - reset: port 4 bits 0,2,3 input, bit 1 analog input
// - port 5 bits 0-4 have direction bits and input pull-ups
// - reset puts all mounted port 5 pins in input mode
// - port 6 bits 0-1 have direction, no pull-up, drive only low
// - reset puts both port 6 pins in input mode
// - port 7 pins have direction bits and input pull-ups
// - reset puts all mounted port 7 pins in input mode
// - port 12 bits 0,5,6,7 bidirectional with latch, direction, pull-up
// - port 12 bits 1-4 input only, no direction, pull-up or drive
// - port 12 bit 0 selectable digital or analog input
// - reset: port 12 bit 0 analog, bits 1-7 input
// - port 13 bit 0 fixed output with latch, bit 7 fixed input
// - port 13 bit 0 driven low while reset is asserted
// - port 14 bits 0-7 have direction bits and input pull-ups
// - port 14 bits 2-5 selectable digital or analog input
// - reset: port 14 bits 0,1,6,7 input, bits 2-5 analog
// - mounted bits depend on the package pin count
// - direction 0 is output, 1 is input; resets to all ones
// - data read gives pin level in input, latch in output mode
// - pull-up off in output mode or analog mode
// - analog pin read in input mode returns 0
`timescale 1ns/1ps
`include "gpio_bank_consts.svh"

module gpio_bank #(
    parameter int VARIANT_PINS = `GPIO_VARIANT_DEFAULT
) (
    input wire logic clock_in,
    input wire logic rstn_in,
    input wire gpio_bank_pkg::bus_req_t bus_req_in,
    input wire gpio_bank_pkg::port_bytes_t pin_in,
    output gpio_bank_pkg::pad_t pad_out,
    output gpio_bank_pkg::bus_rsp_t rsp_out
);

    generate
        if (VARIANT_PINS != 64 && VARIANT_PINS != 52 && VARIANT_PINS != 48 &&
            VARIANT_PINS != 44 && VARIANT_PINS != 32) begin : g_bad_variant
            $error("gpio_bank: VARIANT_PINS must be 32, 44, 48, 52 or 64");
        end
    endgenerate

    // ----------------------------------------------------------------
    // pin capabilities of the full layout and the mounted subset
    // ----------------------------------------------------------------
    function automatic gpio_bank_pkg::port_bytes_t cap_dir();
        return {8'hFF, 8'h00, 8'hE1, 8'h1F, 8'h03, 8'h1F, 8'h0F, 8'h07};
    endfunction

    function automatic gpio_bank_pkg::port_bytes_t cap_pull();
        return {8'hFF, 8'h00, 8'hE1, 8'h1F, 8'h00, 8'h1F, 8'h0F, 8'h07};
    endfunction

    function automatic gpio_bank_pkg::port_bytes_t cap_anlg();
        return {8'h3C, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00};
    endfunction

    // input-only pins and the fixed output pin have no direction bit
    function automatic gpio_bank_pkg::port_bytes_t cap_in_only();
        return {8'h00, 8'h80, 8'h1E, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    endfunction

    function automatic gpio_bank_pkg::port_bytes_t cap_fixed_out();
        return {8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    endfunction

    // smaller packages lose pins from the top of ports 3, 4, 5, 7 and 14, bits 0 and 3-5 of port 12 and bit 0 of port 13
    function automatic gpio_bank_pkg::port_bytes_t mounted(input int pins);
        case (pins)
            64: return {8'hFF, 8'h81, 8'hFF, 8'h1F, 8'h03, 8'h1F, 8'h0F, 8'h07};
            52: return {8'h3F, 8'h80, 8'hFF, 8'h03, 8'h03, 8'h03, 8'h07, 8'h07};
            48: return {8'h1F, 8'h80, 8'hFF, 8'h01, 8'h03, 8'h01, 8'h03, 8'h07};
            44: return {8'h0F, 8'h80, 8'hFF, 8'h00, 8'h03, 8'h00, 8'h01, 8'h07};
            default: return {8'h0F, 8'h80, 8'hC6, 8'h00, 8'h03, 8'h00, 8'h01, 8'h01};
        endcase
    endfunction

    localparam gpio_bank_pkg::port_bytes_t MNT = mounted(VARIANT_PINS);
    localparam gpio_bank_pkg::port_bytes_t M_DIR = cap_dir() & MNT;
    localparam gpio_bank_pkg::port_bytes_t M_PULL = cap_pull() & MNT;
    localparam gpio_bank_pkg::port_bytes_t M_ANLG = cap_anlg() & MNT;
    localparam gpio_bank_pkg::port_bytes_t M_INONLY = cap_in_only() & MNT;
    localparam gpio_bank_pkg::port_bytes_t M_FIXOUT = cap_fixed_out() & MNT;
    localparam gpio_bank_pkg::port_bytes_t M_LAT = (cap_dir() | cap_fixed_out()) & MNT;

    // full-layout capability masks held as constants so the decode can index them
    localparam gpio_bank_pkg::port_bytes_t C_DIR = cap_dir();
    localparam gpio_bank_pkg::port_bytes_t C_PULL = cap_pull();
    localparam gpio_bank_pkg::port_bytes_t C_ANLG = cap_anlg();

    // ----------------------------------------------------------------
    // pad drive derived from the control registers
    // ----------------------------------------------------------------
    function automatic gpio_bank_pkg::pad_t pads(input gpio_bank_pkg::bank_state_t s);
        gpio_bank_pkg::pad_t p;
        logic [7:0] drive;
        p = '0;
        drive = 8'h00;
        for (int i = 0; i < `GPIO_NUM_PORTS; i++) begin
            // direction 0 turns the buffer on; analog pins never drive
            drive = (~s.dir[i] & M_DIR[i] & ~(s.anl[i] & M_ANLG[i])) | M_FIXOUT[i];
            if (i == int'(`GPIO_IDX_P6)) begin
                // open drain: pull low for a 0, release for a 1
                p.level[i] = 8'h00;
                p.oe[i] = drive & ~s.lat[i];
            end else begin
                p.level[i] = s.lat[i] & M_LAT[i];
                p.oe[i] = drive;
            end
            // pull-up only on input-mode digital pins
            p.pull[i] = s.pu[i] & M_PULL[i] & s.dir[i] & ~(s.anl[i] & M_ANLG[i]);
        end
        return p;
    endfunction

    function automatic gpio_bank_pkg::bank_state_t init_state();
        gpio_bank_pkg::bank_state_t s;
        s = '0;
        for (int i = 0; i < `GPIO_NUM_PORTS; i++) begin
            s.dir[i] = `GPIO_DIR_RESET;
            s.lat[i] = `GPIO_DATA_RESET;
            s.pu[i] = `GPIO_PULL_RESET;
            s.anl[i] = `GPIO_ANLG_RESET;
        end
        s.pu[`GPIO_IDX_P4] = `GPIO_PULL4_RESET;
        s.anl[`GPIO_IDX_P4] = `GPIO_ANLG4_RESET;
        s.anl[`GPIO_IDX_P12] = `GPIO_ANLG12_RESET;
        s.anl[`GPIO_IDX_P14] = `GPIO_ANLG14_RESET;
        // port 13 bit 0 comes out of reset driving its cleared latch, i.e. low
        s.pad = pads(s);
        return s;
    endfunction

    localparam gpio_bank_pkg::bank_state_t RESET_STATE = init_state();

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    function automatic logic [3:0] slot_of(input logic [3:0] port_num);
        case (port_num)
            4'h3: return {1'b1, `GPIO_IDX_P3};
            4'h4: return {1'b1, `GPIO_IDX_P4};
            4'h5: return {1'b1, `GPIO_IDX_P5};
            4'h6: return {1'b1, `GPIO_IDX_P6};
            4'h7: return {1'b1, `GPIO_IDX_P7};
            4'hC: return {1'b1, `GPIO_IDX_P12};
            4'hD: return {1'b1, `GPIO_IDX_P13};
            4'hE: return {1'b1, `GPIO_IDX_P14};
            default: return 4'h0;
        endcase
    endfunction

    localparam logic [15:0] DATA_PAGE = 16'(`GPIO_DATA_BASE >> 4);
    localparam logic [15:0] DIR_PAGE = 16'(`GPIO_DIR_BASE >> 4);
    localparam logic [15:0] PULL_PAGE = 16'(`GPIO_PULL_BASE >> 4);
    localparam logic [15:0] ANLG_PAGE = 16'(`GPIO_ANLG_BASE >> 4);

    gpio_bank_pkg::bank_state_t q;
    gpio_bank_pkg::bank_state_t d;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        logic [3:0] slot;
        logic [2:0] i;
        logic [15:0] page;
        logic hit_data;
        logic hit_dir;
        logic hit_pull;
        logic hit_anlg;
        logic [7:0] in_mode;
        logic [7:0] out_mode;
        logic [7:0] wd;
        slot = slot_of(bus_req_in.addr[3:0]);
        i = slot[2:0];
        page = bus_req_in.addr[`GPIO_ADDR_W-1:4];
        wd = bus_req_in.wdata;
        // a register exists only where the full layout gives it a bit
        hit_data = slot[3] && page == DATA_PAGE;
        hit_dir = slot[3] && page == DIR_PAGE && C_DIR[i] != 8'h00;
        hit_pull = slot[3] && page == PULL_PAGE && C_PULL[i] != 8'h00;
        hit_anlg = slot[3] && page == ANLG_PAGE && C_ANLG[i] != 8'h00;
        in_mode = (q.dir[i] & M_DIR[i]) | M_INONLY[i];
        out_mode = (~q.dir[i] & M_DIR[i]) | M_FIXOUT[i];
        d = q;
        d.rsp = '0;
        if (bus_req_in.wr) begin
            // unmounted bits keep their reset value whatever is written
            if (hit_data) begin
                d.lat[i] = (q.lat[i] & ~M_LAT[i]) | (wd & M_LAT[i]);
            end
            if (hit_dir) begin
                d.dir[i] = (q.dir[i] & ~M_DIR[i]) | (wd & M_DIR[i]);
            end
            if (hit_pull) begin
                d.pu[i] = (q.pu[i] & ~M_PULL[i]) | (wd & M_PULL[i]);
            end
            if (hit_anlg) begin
                d.anl[i] = (q.anl[i] & ~M_ANLG[i]) | (wd & M_ANLG[i]);
            end
        end
        if (bus_req_in.rd) begin
            d.rsp.rvalid = 1'b1;
            if (hit_data) begin
                d.rsp.rdata = (in_mode & pin_in[i] & ~(q.anl[i] & M_ANLG[i])) |
                              (out_mode & q.lat[i]);
            end else if (hit_dir) begin
                d.rsp.rdata = q.dir[i];
            end else if (hit_pull) begin
                d.rsp.rdata = q.pu[i];
            end else if (hit_anlg) begin
                d.rsp.rdata = q.anl[i];
            end else begin
                d.rsp.rdata = 8'h00;
            end
        end
        d.pad = pads(d);
    end

    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            q <= RESET_STATE;
        end else begin
            q <= d;
        end
    end

    assign pad_out = q.pad;
    assign rsp_out = q.rsp;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rstn_in);

    sequence s_write(logic [15:0] pg, logic [3:0] pn);
        bus_req_in.wr && bus_req_in.addr == {pg, pn};
    endsequence

    sequence s_read(logic [15:0] pg, logic [3:0] pn);
        bus_req_in.rd && !bus_req_in.wr && bus_req_in.addr == {pg, pn};
    endsequence

    AST_OD_NEVER_HIGH: assert property (
        pad_out.level[`GPIO_IDX_P6] == 8'h00 && pad_out.pull[`GPIO_IDX_P6] == 8'h00)
        else $error("port 6 drove high or pulled up");

    AST_OD_LOW_ON_ZERO: assert property (
        s_write(DATA_PAGE, 4'h6) ##1 s_write(DIR_PAGE, 4'h6) |=>
        pad_out.oe[`GPIO_IDX_P6] == (~$past(bus_req_in.wdata) & ~$past(bus_req_in.wdata, 2)
                                     & M_DIR[`GPIO_IDX_P6]))
        else $error("port 6 open-drain enable wrong");

    AST_INPUT_ONLY: assert property (
        (pad_out.oe[`GPIO_IDX_P12] & M_INONLY[`GPIO_IDX_P12]) == 8'h00 &&
        (pad_out.oe[`GPIO_IDX_P13] & M_INONLY[`GPIO_IDX_P13]) == 8'h00)
        else $error("input-only pin is driven");

    AST_FIXED_OUT: assert property (
        s_write(DATA_PAGE, 4'hD) |=> pad_out.oe[`GPIO_IDX_P13][0] == M_FIXOUT[`GPIO_IDX_P13][0]
        && pad_out.level[`GPIO_IDX_P13][0] == ($past(bus_req_in.wdata[0]) & MNT[`GPIO_IDX_P13][0]))
        else $error("port 13 bit 0 does not follow its latch");

    AST_PULL_OFF: assert property (
        (pad_out.pull[`GPIO_IDX_P14] & pad_out.oe[`GPIO_IDX_P14]) == 8'h00 &&
        (pad_out.pull[`GPIO_IDX_P14] & q.anl[`GPIO_IDX_P14] & M_ANLG[`GPIO_IDX_P14]) == 8'h00)
        else $error("pull-up on while driving or analog");

    AST_ANALOG_READS_ZERO: assert property (
        s_read(DATA_PAGE, 4'hC) ##0 (q.anl[`GPIO_IDX_P12][0] && q.dir[`GPIO_IDX_P12][0])
        |=> rsp_out.rvalid && !rsp_out.rdata[0])
        else $error("analog pin read returned its level");

    AST_DIR_TO_DRIVE: assert property (
        s_write(ANLG_PAGE, 4'hE) ##1 s_write(DIR_PAGE, 4'hE) |=>
        pad_out.oe[`GPIO_IDX_P14] == (~$past(bus_req_in.wdata) & M_DIR[`GPIO_IDX_P14] &
                                      ~($past(bus_req_in.wdata, 2) & M_ANLG[`GPIO_IDX_P14])))
        else $error("port 14 drive does not follow direction");

    AST_LATCH_KEPT: assert property (
        s_write(DATA_PAGE, 4'h5) ##1 (!bus_req_in.wr [*2]) |->
        pad_out.level[`GPIO_IDX_P5] == ($past(bus_req_in.wdata, 2) & M_LAT[`GPIO_IDX_P5]))
        else $error("port 5 latch lost its value");

    AST_READ_PIN: assert property (
        s_read(DATA_PAGE, 4'h3) ##0 (q.dir[`GPIO_IDX_P3] == 8'hFF) |=>
        rsp_out.rdata == ($past(pin_in[`GPIO_IDX_P3]) & M_DIR[`GPIO_IDX_P3]))
        else $error("input-mode read did not return pin level");

    // ----------------------------------------------------------------
    // reset, answer timing and per-register write checks
    // ----------------------------------------------------------------

    AST_RESET_P13_LOW: assert property (@(posedge clock_in) disable iff (1'b0)
        !rstn_in ##1 !rstn_in |->
        pad_out.oe[`GPIO_IDX_P13][0] == M_FIXOUT[`GPIO_IDX_P13][0] &&
        !pad_out.level[`GPIO_IDX_P13][0])
        else $error("port 13 bit 0 not held low in reset");

    AST_READ_ANSWER: assert property (
        bus_req_in.rd |=> rsp_out.rvalid)
        else $error("read got no answer in the next cycle");

    AST_IDLE_QUIET: assert property (
        !bus_req_in.rd |=> !rsp_out.rvalid && rsp_out.rdata == 8'h00)
        else $error("read answer without a read");

    AST_DIR_WRITE_P3: assert property (
        s_write(DIR_PAGE, 4'h3) |=> (q.dir[`GPIO_IDX_P3] & M_DIR[`GPIO_IDX_P3]) ==
        ($past(bus_req_in.wdata) & M_DIR[`GPIO_IDX_P3]))
        else $error("port 3 direction write lost");

    AST_DIR_WRITE_P4: assert property (
        s_write(DIR_PAGE, 4'h4) |=> (q.dir[`GPIO_IDX_P4] & M_DIR[`GPIO_IDX_P4]) ==
        ($past(bus_req_in.wdata) & M_DIR[`GPIO_IDX_P4]))
        else $error("port 4 direction write lost");

    AST_DIR_WRITE_P5: assert property (
        s_write(DIR_PAGE, 4'h5) |=> (q.dir[`GPIO_IDX_P5] & M_DIR[`GPIO_IDX_P5]) ==
        ($past(bus_req_in.wdata) & M_DIR[`GPIO_IDX_P5]))
        else $error("port 5 direction write lost");

    AST_DIR_WRITE_P7: assert property (
        s_write(DIR_PAGE, 4'h7) |=> (q.dir[`GPIO_IDX_P7] & M_DIR[`GPIO_IDX_P7]) ==
        ($past(bus_req_in.wdata) & M_DIR[`GPIO_IDX_P7]))
        else $error("port 7 direction write lost");

    AST_DIR_WRITE_P12: assert property (
        s_write(DIR_PAGE, 4'hC) |=> (q.dir[`GPIO_IDX_P12] & M_DIR[`GPIO_IDX_P12]) ==
        ($past(bus_req_in.wdata) & M_DIR[`GPIO_IDX_P12]))
        else $error("port 12 direction write lost");

    AST_DIR_WRITE_P14: assert property (
        s_write(DIR_PAGE, 4'hE) |=> (q.dir[`GPIO_IDX_P14] & M_DIR[`GPIO_IDX_P14]) ==
        ($past(bus_req_in.wdata) & M_DIR[`GPIO_IDX_P14]))
        else $error("port 14 direction write lost");

    AST_PULL_WRITE_P3: assert property (
        s_write(PULL_PAGE, 4'h3) |=> (q.pu[`GPIO_IDX_P3] & M_PULL[`GPIO_IDX_P3]) ==
        ($past(bus_req_in.wdata) & M_PULL[`GPIO_IDX_P3]))
        else $error("port 3 pull-up write lost");

    AST_PULL_WRITE_P14: assert property (
        s_write(PULL_PAGE, 4'hE) |=> (q.pu[`GPIO_IDX_P14] & M_PULL[`GPIO_IDX_P14]) ==
        ($past(bus_req_in.wdata) & M_PULL[`GPIO_IDX_P14]))
        else $error("port 14 pull-up write lost");

    AST_ANLG_WRITE_P12: assert property (
        s_write(ANLG_PAGE, 4'hC) |=> q.anl[`GPIO_IDX_P12][0] ==
        ($past(bus_req_in.wdata[0]) & M_ANLG[`GPIO_IDX_P12][0]))
        else $error("port 12 analog select write lost");

    AST_ANLG_NO_DRIVE: assert property (
        (pad_out.oe[`GPIO_IDX_P14] & q.anl[`GPIO_IDX_P14] & M_ANLG[`GPIO_IDX_P14]) == 8'h00)
        else $error("analog pin of port 14 is driven");

    AST_UNMOUNTED_KEPT: assert property (
        (q.dir[`GPIO_IDX_P3] | M_DIR[`GPIO_IDX_P3]) == 8'hFF &&
        (q.lat[`GPIO_IDX_P3] & ~M_LAT[`GPIO_IDX_P3]) == 8'h00)
        else $error("unmounted port 3 bit left its reset value");

    AST_INPUT_ONLY_NO_PULL: assert property (
        (pad_out.pull[`GPIO_IDX_P12] & M_INONLY[`GPIO_IDX_P12]) == 8'h00)
        else $error("input-only pin has a pull-up");

endmodule

// file: gpio_bank_consts.svh
// Constants of the general-purpose I/O bank: register addresses, reset values, port slot indices.
// Included by the package and the bank; holds definitions only.
`ifndef GPIO_BANK_CONSTS_SVH
`define GPIO_BANK_CONSTS_SVH

// ----------------------------------------------------------------
// sizes
// ----------------------------------------------------------------
`define GPIO_NUM_PORTS 8
`define GPIO_ADDR_W 20
`define GPIO_VARIANT_DEFAULT 64

// ----------------------------------------------------------------
// register regions; low nibble of the address is the port number
// ----------------------------------------------------------------
`define GPIO_DATA_BASE 20'hFFF00
`define GPIO_DIR_BASE 20'hFFF20
`define GPIO_PULL_BASE 20'hF0030
`define GPIO_ANLG_BASE 20'hF0060

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define GPIO_DIR_RESET 8'hFF
`define GPIO_DATA_RESET 8'h00
`define GPIO_PULL_RESET 8'h00
`define GPIO_PULL4_RESET 8'h01
`define GPIO_ANLG_RESET 8'h00
`define GPIO_ANLG4_RESET 8'h02
`define GPIO_ANLG12_RESET 8'h01
`define GPIO_ANLG14_RESET 8'h3C

// ----------------------------------------------------------------
// port slots (index into the bank arrays)
// ----------------------------------------------------------------
`define GPIO_IDX_P3 3'h0
`define GPIO_IDX_P4 3'h1
`define GPIO_IDX_P5 3'h2
`define GPIO_IDX_P6 3'h3
`define GPIO_IDX_P7 3'h4
`define GPIO_IDX_P12 3'h5
`define GPIO_IDX_P13 3'h6
`define GPIO_IDX_P14 3'h7

`endif

// file: gpio_bank_pkg.sv
// Types shared by the I/O bank and whoever instantiates it.
// Assumes the constants header is on the include path.
`include "gpio_bank_consts.svh"

package gpio_bank_pkg;

    // one byte per port slot, slot order 3,4,5,6,7,12,13,14
    typedef logic [`GPIO_NUM_PORTS-1:0][7:0] port_bytes_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [`GPIO_ADDR_W-1:0] addr;
        logic [7:0] wdata;
    } bus_req_t;

    typedef struct packed {
        logic rvalid;
        logic [7:0] rdata;
    } bus_rsp_t;

    typedef struct packed {
        port_bytes_t level;
        port_bytes_t oe;
        port_bytes_t pull;
    } pad_t;

    typedef struct packed {
        port_bytes_t dir;
        port_bytes_t lat;
        port_bytes_t pu;
        port_bytes_t anl;
        pad_t pad;
        bus_rsp_t rsp;
    } bank_state_t;

endpackage

// file: gpio_board.sv
// Board model: resolves each pin from the bank's drive, its pull-up and an outside source.
// Assumes pad and outside values are settled before the bank samples its pins.
`timescale 1ns/1ps

module gpio_board (
    input wire gpio_bank_pkg::pad_t pad_in,
    input wire gpio_bank_pkg::port_bytes_t ext_in,
    output gpio_bank_pkg::port_bytes_t pin_out
);
    // --------------------------------------------------------
    // wire resolution
    // --------------------------------------------------------
    // an undriven pin without pull-up follows the outside source, which the bench reshuffles,
    // so a stale level never passes for a real one
    always_comb begin
        for (int i = 0; i < 64; i++) begin
            if (pad_in.oe[i / 8][i % 8]) begin
                pin_out[i / 8][i % 8] = pad_in.level[i / 8][i % 8];
            end else if (pad_in.pull[i / 8][i % 8]) begin
                pin_out[i / 8][i % 8] = 1'b1;
            end else begin
                pin_out[i / 8][i % 8] = ext_in[i / 8][i % 8];
            end
        end
    end
endmodule

// file: tb.sv
// Self-checking bench of the I/O bank with a register-level reference model.
// Assumes the constants header and the package are compiled first.
`timescale 1ns/1ps
`include "gpio_bank_consts.svh"

module tb;
    logic clock_in = 1'b0;
    logic rstn_in = 1'b0;
    gpio_bank_pkg::bus_req_t req = '0;
    gpio_bank_pkg::port_bytes_t pins;
    gpio_bank_pkg::port_bytes_t ext = '0;
    gpio_bank_pkg::pad_t pad;
    gpio_bank_pkg::bus_rsp_t rsp;
    int n_errors = 0;
    int checked = 0;
    int cycles = 0;
    logic [31:0] seed = 32'h11C5;
    logic [7:0] dir_m [8];
    logic [7:0] lat_m [8];
    logic [7:0] pu_m [8];
    logic [7:0] anl_m [8];
    // slot order: ports 3,4,5,6,7,12,13,14
    localparam logic [7:0] PN [8] = '{8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h0C, 8'h0D, 8'h0E};
    localparam logic [7:0] WM [8] = '{8'h07, 8'h0F, 8'h1F, 8'h03, 8'h1F, 8'hE1, 8'h01, 8'hFF};
    localparam logic [7:0] PM [8] = '{8'h07, 8'h0F, 8'h1F, 8'h00, 8'h1F, 8'hE1, 8'h00, 8'hFF};
    localparam logic [7:0] AM [8] = '{8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h3C};
    localparam logic [7:0] RM [8] = '{8'h07, 8'h0F, 8'h1F, 8'h03, 8'h1F, 8'hFF, 8'h81, 8'hFF};

    gpio_bank #(.VARIANT_PINS(64)) u_dut (
        .clock_in(clock_in),
        .rstn_in(rstn_in),
        .bus_req_in(req),
        .pin_in(pins),
        .pad_out(pad),
        .rsp_out(rsp)
    );
    gpio_board u_board (
        .pad_in(pad),
        .ext_in(ext),
        .pin_out(pins)
    );

    initial begin
        forever #25 clock_in = ~clock_in;
    end

    // --------------------------------------------------------
    // reference model
    // --------------------------------------------------------
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [7:0] oe_e(int s);
        if (s == 3) return ~dir_m[s] & ~lat_m[s] & RM[s];
        return ~dir_m[s] & ~anl_m[s] & RM[s];
    endfunction
    function automatic logic [7:0] lv_e(int s);
        return (s == 3) ? 8'h00 : lat_m[s];
    endfunction
    function automatic logic [7:0] pu_e(int s);
        return pu_m[s] & dir_m[s] & ~anl_m[s];
    endfunction
    function automatic logic [7:0] pin_e(int s);
        return (oe_e(s) & lv_e(s)) | (~oe_e(s) & (pu_e(s) | ext[s]));
    endfunction
    function automatic bit mapped(int s, int r);
        return r == 0 || (r == 1 && s != 6) || (r == 2 && PM[s] != 0) || (r == 3 && AM[s] != 0);
    endfunction
    function automatic logic [7:0] rd_e(int s, int r);
        if (!mapped(s, r)) return 8'h00;
        if (r == 1) return dir_m[s];
        if (r == 2) return pu_m[s];
        if (r == 3) return anl_m[s];
        return RM[s] & ((~dir_m[s] & lat_m[s]) |
                        (dir_m[s] & ~anl_m[s] & pin_e(s)));
    endfunction
    task automatic model_reset();
        for (int s = 0; s < 8; s++) begin
            dir_m[s] = (s == 6) ? 8'hFE : 8'hFF;
            lat_m[s] = 8'h00;
            pu_m[s] = (s == 1) ? 8'h01 : 8'h00;
            anl_m[s] = AM[s];
        end
    endtask

    // --------------------------------------------------------
    // bus, compares and verdict
    // --------------------------------------------------------
    function automatic logic [19:0] addr_of(int s, int r);
        logic [19:0] b;
        b = (r == 0) ? `GPIO_DATA_BASE : (r == 1) ? `GPIO_DIR_BASE : (r == 2) ? `GPIO_PULL_BASE
            : `GPIO_ANLG_BASE;
        return b | {12'h000, PN[s]};
    endfunction
    task automatic cmp_pad(int s);
        checked++;
        if (pad.oe[s] !== oe_e(s) || pad.pull[s] !== pu_e(s)
            || (pad.level[s] & oe_e(s)) !== (lv_e(s) & oe_e(s))) begin
            n_errors++;
            $display("CHECK FAILED t=%0t pad slot %0d oe %h pull %h", $time, s, pad.oe[s],
                pad.pull[s]);
        end
    endtask
    task automatic cmp_read(int s, int r, logic [7:0] exp);
        checked++;
        if (rsp.rvalid !== 1'b1 || rsp.rdata !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t read slot %0d reg %0d got %h exp %h", $time, s, r,
                rsp.rdata, exp);
        end
    endtask
    function automatic void model_wr(int s, int r, logic [7:0] w);
        if (mapped(s, r) && r == 0) lat_m[s] = w & WM[s];
        if (mapped(s, r) && r == 1) dir_m[s] = w | ~WM[s];
        if (mapped(s, r) && r == 2) pu_m[s] = w & PM[s];
        if (mapped(s, r) && r == 3) anl_m[s] = w & AM[s];
    endfunction
    task automatic bus_wr(int s, int r, logic [7:0] w);
        @(posedge clock_in);
        req.wr <= 1'b1;
        req.addr <= addr_of(s, r);
        req.wdata <= w;
        @(posedge clock_in);
        req.wr <= 1'b0;
        #1;
        model_wr(s, r, w);
    endtask
    // two writes to one port on consecutive edges, strobe held high between them
    task automatic bus_wr2(int s, int r0, logic [7:0] w0, int r1, logic [7:0] w1);
        @(posedge clock_in);
        req.wr <= 1'b1;
        req.addr <= addr_of(s, r0);
        req.wdata <= w0;
        @(posedge clock_in);
        req.addr <= addr_of(s, r1);
        req.wdata <= w1;
        @(posedge clock_in);
        req.wr <= 1'b0;
        #1;
        model_wr(s, r0, w0);
        model_wr(s, r1, w1);
    endtask
    task automatic bus_rd(int s, int r);
        @(posedge clock_in);
        req.rd <= 1'b1;
        req.addr <= addr_of(s, r);
        @(posedge clock_in);
        req.rd <= 1'b0;
        #1;
        cmp_read(s, r, rd_e(s, r));
    endtask
    task automatic check_all();
        for (int s = 0; s < 8; s++) cmp_pad(s);
        for (int s = 0; s < 8; s++) for (int r = 0; r < 4; r++) bus_rd(s, r);
    endtask
    task automatic end_of_test();
        if (n_errors == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            end_of_test();
        end
    end

    // --------------------------------------------------------
    // main sequence
    // --------------------------------------------------------
    initial begin
        int s;
        int r;
        logic [7:0] w;
        model_reset();
        repeat (20) @(posedge clock_in);
        for (int i = 0; i < 8; i++) cmp_pad(i);
        rstn_in <= 1'b1;
        check_all();
        for (int n = 0; n < 400; n++) begin
            s = int'(xs() % 8);
            r = int'(xs() % 4);
            w = 8'(xs());
            // unmounted bits carry their initial values
            w = (r == 1) ? (w | ~WM[s]) : (r == 2) ? (w & PM[s]) : (r == 3) ? (w & AM[s])
                : (w & WM[s]);
            bus_wr(s, r, w);
            cmp_pad(s);
            ext <= {xs(), xs()};
            bus_rd(int'(xs() % 8), int'(xs() % 4));
        end
        // back-to-back writes reach the two-step drive checks
        for (int n = 0; n < 16; n++) begin
            w = 8'(xs());
            bus_wr2(3, 0, w & WM[3], 1, 8'(xs()) | ~WM[3]);
            cmp_pad(3);
            bus_wr2(7, 3, w & AM[7], 1, 8'(xs()));
            cmp_pad(7);
        end
        @(posedge clock_in);
        rstn_in <= 1'b0;
        @(posedge clock_in);
        #1;
        model_reset();
        for (int i = 0; i < 8; i++) cmp_pad(i);
        @(posedge clock_in);
        rstn_in <= 1'b1;
        check_all();
        end_of_test();
    end
endmodule
